// file: design/hcc_pkg.sv
package hcc_pkg;

	localparam int          CHANNELS      = 32;
	localparam int          CHAN_W        = 5;
	localparam int          LEN_W         = 14;
	localparam int          PAD_W         = 8;
	localparam int          ADDR_W        = 10;

	localparam logic        DIR_TX        = 1'b0;
	localparam logic        DIR_RX        = 1'b1;

	localparam logic [9:0]  OFS_CFG_BASE  = 10'h000;
	localparam logic [9:0]  OFS_MAX_ONE   = 10'h100;
	localparam logic [9:0]  OFS_MAX_TWO   = 10'h104;
	localparam logic [9:0]  OFS_EVENTS    = 10'h108;

	localparam logic [31:0] CFG_RESET     = 32'h0000_0000;
	localparam logic [31:0] CFG_WMASK     = 32'hBFBF_FFC0;
	localparam logic [13:0] MAX_RESET     = 14'h3FFF;
	localparam logic [31:0] EVENTS_RESET  = 32'h0000_0000;

	localparam int          EV_PADFILL    = 0;
	localparam int          EV_ERR_INC    = 1;
	localparam int          EV_ERR_DEC    = 2;
	localparam int          EV_DUP        = 3;
	localparam int          EV_LENGTH     = 4;
	localparam int          EV_W          = 5;

	typedef enum logic [2:0]
	{
		PROTO_TRANSPARENT = 3'h0,
		PROTO_SS7_FCS16   = 3'h1,
		PROTO_HDLC_FCS16  = 3'h2,
		PROTO_HDLC_FCS32  = 3'h3
	} hcc_proto_e;

	localparam logic [1:0]  LIMIT_NONE    = 2'h0;
	localparam logic [1:0]  LIMIT_ONE     = 2'h1;
	localparam logic [1:0]  LIMIT_TWO     = 2'h2;

	typedef struct packed
	{
		logic       pad_adjust_enable;
		logic       rsvd_30;
		logic [5:0] fifo_start_index;
		logic       data_complement;
		logic       rsvd_22;
		logic [5:0] fifo_length_code;
		logic       end_padfill_irq_enable;
		logic [2:0] protocol;
		logic [1:0] length_limit_select;
		logic       fcs_pass_through;
		logic       err_inc_irq_enable;
		logic       err_dec_irq_enable;
		logic       dup_irq_enable;
		logic [5:0] rsvd_low;
	} hcc_cfg_s;

	typedef struct packed
	{
		logic [5:0] fifo_start_index;
		logic [6:0] fifo_words;
		logic       data_complement;
		logic       send_fcs;
		logic       store_fcs;
		logic [2:0] protocol;
	} hcc_chan_s;

endpackage : hcc_pkg

// file: design/hcc_pad_adjust.sv
`timescale 1ns/10ps
module hcc_pad_adjust
(
	input  wire logic                    ref_clk,
	input  wire logic                    srst,
	input  wire logic                    enable,
	input  wire logic                    pad_load,
	input  wire logic [hcc_pkg::PAD_W-1:0] pad_value,
	input  wire logic                    zero_insert,
	output logic [hcc_pkg::PAD_W-1:0]      pad_fill_count
);

	logic [hcc_pkg::PAD_W-1:0] pad_ff;

	// a load in the same cycle as a zero insertion wins: the new frame starts fresh
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			pad_ff <= '0;
		else if (pad_load)
			pad_ff <= pad_value;
		else if (zero_insert && enable && (pad_ff != '0))
			pad_ff <= pad_ff - 1'b1;
	end

	assign pad_fill_count = pad_ff;

	AST_PAD_HOLD: assert property (@(posedge ref_clk) disable iff (srst)
		(zero_insert && !enable && !pad_load) |=> $stable(pad_fill_count))
		else $error("pad count moved with adjustment off");

	AST_PAD_DEC: assert property (@(posedge ref_clk) disable iff (srst)
		(zero_insert && enable && !pad_load && pad_fill_count != '0)
		|=> pad_fill_count == $past(pad_fill_count) - 1'b1)
		else $error("pad count not reduced on zero insertion");

endmodule : hcc_pad_adjust

// file: design/hcc_len_check.sv
`timescale 1ns/10ps
module hcc_len_check
(
	input  wire logic                      ref_clk,
	input  wire logic                      srst,
	input  wire logic [1:0]                limit_select,
	input  wire logic [hcc_pkg::LEN_W-1:0] max_one,
	input  wire logic [hcc_pkg::LEN_W-1:0] max_two,
	input  wire logic                      byte_valid,
	input  wire logic                      msg_end,
	output logic                           length_error
);

	logic [hcc_pkg::LEN_W:0]   count_ff;
	logic                      flagged_ff;
	logic                      err_ff;
	logic [hcc_pkg::LEN_W-1:0] limit;
	logic                      over;

	always_comb
	begin
		limit = max_one;
		if (limit_select == hcc_pkg::LIMIT_TWO)
			limit = max_two;
	end

	// select value 3 is left unchecked, like value 0
	assign over = byte_valid && !flagged_ff && (count_ff >= {1'b0, limit})
		&& ((limit_select == hcc_pkg::LIMIT_ONE) || (limit_select == hcc_pkg::LIMIT_TWO));

	always_ff @(posedge ref_clk)
	begin
		if (srst || msg_end)
			count_ff <= '0;
		else if (byte_valid && count_ff[hcc_pkg::LEN_W] == 1'b0)
			count_ff <= count_ff + 1'b1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst || msg_end)
			flagged_ff <= 1'b0;
		else if (over)
			flagged_ff <= 1'b1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			err_ff <= 1'b0;
		else
			err_ff <= over;
	end

	assign length_error = err_ff;

	AST_NO_CHECK: assert property (@(posedge ref_clk) disable iff (srst)
		(limit_select == hcc_pkg::LIMIT_NONE) |=> !length_error)
		else $error("length error with checking off");

	AST_LIMIT: assert property (@(posedge ref_clk) disable iff (srst)
		(byte_valid && !msg_end && !flagged_ff && limit_select == hcc_pkg::LIMIT_ONE && count_ff == {1'b0, max_one})
		|=> length_error)
		else $error("overlong message not flagged against first limit");

endmodule : hcc_len_check

// file: design/hcc_channel_config.sv
// Implementation choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module hcc_channel_config
(
	input  wire logic                              ref_clk,
	input  wire logic                              srst,
	input  wire logic [hcc_pkg::ADDR_W-1:0]        avs_address,
	input  wire logic                              avs_read,
	input  wire logic                              avs_write,
	input  wire logic [3:0]                        avs_byteenable,
	input  wire logic [31:0]                       avs_writedata,
	output logic [31:0]                            avs_readdata,
	output logic                                   avs_waitrequest,
	input  wire logic [hcc_pkg::CHAN_W-1:0]        tx_chan,
	input  wire logic [hcc_pkg::CHAN_W-1:0]        rx_chan,
	output hcc_pkg::hcc_chan_s                     tx_setup,
	output hcc_pkg::hcc_chan_s                     rx_setup,
	input  wire logic                              tx_pad_load,
	input  wire logic [hcc_pkg::PAD_W-1:0]         tx_pad_value,
	input  wire logic                              tx_zero_insert,
	output logic [hcc_pkg::PAD_W-1:0]              pad_fill_count,
	input  wire logic                              tx_padfill_done,
	output logic                                   end_padfill_irq,
	input  wire logic                              rx_byte_valid,
	input  wire logic                              rx_msg_end,
	output logic                                   rx_length_error,
	input  wire logic                              err_count_inc,
	input  wire logic                              err_count_dec,
	input  wire logic                              rx_duplicate,
	output logic                                   err_inc_irq,
	output logic                                   err_dec_irq,
	output logic                                   dup_irq
);

	logic [31:0]                  cfg_mem [0:2*hcc_pkg::CHANNELS-1];
	logic [hcc_pkg::LEN_W-1:0]    max_one_ff;
	logic [hcc_pkg::LEN_W-1:0]    max_two_ff;
	logic [hcc_pkg::EV_W-1:0]     events_ff;
	logic                         ack_ff;
	logic [31:0]                  rdata_ff;
	hcc_pkg::hcc_chan_s           tx_setup_ff;
	hcc_pkg::hcc_chan_s           rx_setup_ff;
	logic                         eop_irq_ff;
	logic                         inc_irq_ff;
	logic                         dec_irq_ff;
	logic                         dup_irq_ff;
	hcc_pkg::hcc_cfg_s            tx_cfg;
	hcc_pkg::hcc_cfg_s            rx_cfg;
	logic                         ss7_rx;
	logic                         wr_go;
	logic                         in_cfg;
	logic [5:0]                   cfg_idx;
	logic [hcc_pkg::EV_W-1:0]     ev_set;
	logic [31:0]                  nxt_rdata;

	function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[8*i +: 8] = wd[8*i +: 8];
		return r;
	endfunction : merge_be

	function automatic hcc_pkg::hcc_chan_s derive(input hcc_pkg::hcc_cfg_s c);
		hcc_pkg::hcc_chan_s s;
		s.fifo_start_index = c.fifo_start_index;
		s.fifo_words       = 7'({c.fifo_length_code, 1'b0}) + 7'h02;
		s.data_complement  = c.data_complement;
		s.send_fcs         = !c.fcs_pass_through && (c.protocol != hcc_pkg::PROTO_TRANSPARENT);
		s.store_fcs        = c.fcs_pass_through;
		s.protocol         = c.protocol;
		return s;
	endfunction : derive

	// slot 0..31 transmit, 32..63 receive, one word each
	assign tx_cfg  = hcc_pkg::hcc_cfg_s'(cfg_mem[{hcc_pkg::DIR_TX, tx_chan}]);
	assign rx_cfg  = hcc_pkg::hcc_cfg_s'(cfg_mem[{hcc_pkg::DIR_RX, rx_chan}]);
	assign ss7_rx  = (rx_cfg.protocol == hcc_pkg::PROTO_SS7_FCS16);
	assign in_cfg  = (avs_address[9:8] == hcc_pkg::OFS_CFG_BASE[9:8]);
	assign cfg_idx = avs_address[7:2];
	// every access costs exactly one wait cycle; the array read needs it
	assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
	assign wr_go   = avs_write && ack_ff;

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			ack_ff <= 1'b0;
		else
			ack_ff <= (avs_read || avs_write) && !ack_ff;
	end

	always_comb
	begin
		nxt_rdata = 32'h0000_0000;
		if (in_cfg)
			nxt_rdata = cfg_mem[cfg_idx];
		else if (avs_address == hcc_pkg::OFS_MAX_ONE)
			nxt_rdata = 32'(max_one_ff);
		else if (avs_address == hcc_pkg::OFS_MAX_TWO)
			nxt_rdata = 32'(max_two_ff);
		else if (avs_address == hcc_pkg::OFS_EVENTS)
			nxt_rdata = 32'(events_ff);
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			rdata_ff <= 32'h0000_0000;
		else if (avs_read && !ack_ff)
			rdata_ff <= nxt_rdata;
	end

	assign avs_readdata = rdata_ff;

	// reserved bits are dropped on write so they always read back as zero
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			for (int i = 0; i < 2*hcc_pkg::CHANNELS; i++)
				cfg_mem[i] <= hcc_pkg::CFG_RESET;
		end
		else if (wr_go && in_cfg)
			cfg_mem[cfg_idx] <= merge_be(cfg_mem[cfg_idx], avs_writedata, avs_byteenable)
				& hcc_pkg::CFG_WMASK;
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			max_one_ff <= hcc_pkg::MAX_RESET;
			max_two_ff <= hcc_pkg::MAX_RESET;
		end
		else if (wr_go && avs_address == hcc_pkg::OFS_MAX_ONE)
			max_one_ff <= hcc_pkg::LEN_W'(merge_be(32'(max_one_ff), avs_writedata, avs_byteenable));
		else if (wr_go && avs_address == hcc_pkg::OFS_MAX_TWO)
			max_two_ff <= hcc_pkg::LEN_W'(merge_be(32'(max_two_ff), avs_writedata, avs_byteenable));
	end

	assign ev_set = {rx_length_error, dup_irq_ff, dec_irq_ff, inc_irq_ff, eop_irq_ff};

	// write one to clear; a new event in the clearing cycle stays set
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			events_ff <= hcc_pkg::EV_W'(hcc_pkg::EVENTS_RESET);
		else if (wr_go && avs_address == hcc_pkg::OFS_EVENTS && avs_byteenable[0])
			events_ff <= (events_ff & ~avs_writedata[hcc_pkg::EV_W-1:0]) | ev_set;
		else
			events_ff <= events_ff | ev_set;
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			tx_setup_ff <= '0;
			rx_setup_ff <= '0;
		end
		else
		begin
			tx_setup_ff <= derive(tx_cfg);
			rx_setup_ff <= derive(rx_cfg);
		end
	end

	assign tx_setup = tx_setup_ff;
	assign rx_setup = rx_setup_ff;

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			eop_irq_ff <= 1'b0;
			inc_irq_ff <= 1'b0;
			dec_irq_ff <= 1'b0;
			dup_irq_ff <= 1'b0;
		end
		else
		begin
			eop_irq_ff <= tx_padfill_done && tx_cfg.end_padfill_irq_enable;
			inc_irq_ff <= err_count_inc && ss7_rx && rx_cfg.err_inc_irq_enable;
			dec_irq_ff <= err_count_dec && ss7_rx && rx_cfg.err_dec_irq_enable;
			dup_irq_ff <= rx_duplicate && ss7_rx && rx_cfg.dup_irq_enable;
		end
	end

	assign end_padfill_irq = eop_irq_ff;
	assign err_inc_irq     = inc_irq_ff;
	assign err_dec_irq     = dec_irq_ff;
	assign dup_irq         = dup_irq_ff;

	hcc_pad_adjust u_pad
	(
		.ref_clk        (ref_clk),
		.srst           (srst),
		.enable         (tx_cfg.pad_adjust_enable),
		.pad_load       (tx_pad_load),
		.pad_value      (tx_pad_value),
		.zero_insert    (tx_zero_insert),
		.pad_fill_count (pad_fill_count)
	);

	// one receive message checked at a time; the caller keeps rx_chan steady through a message
	hcc_len_check u_len
	(
		.ref_clk      (ref_clk),
		.srst         (srst),
		.limit_select (rx_cfg.length_limit_select),
		.max_one      (max_one_ff),
		.max_two      (max_two_ff),
		.byte_valid   (rx_byte_valid),
		.msg_end      (rx_msg_end),
		.length_error (rx_length_error)
	);

	AST_WAIT_ONE: assert property (@(posedge ref_clk) disable iff (srst)
		((avs_read || avs_write) && !ack_ff) |=> !avs_waitrequest)
		else $error("waitrequest held past one cycle");

	AST_EOP_OFF: assert property (@(posedge ref_clk) disable iff (srst)
		(tx_padfill_done && !tx_cfg.end_padfill_irq_enable) |=> !end_padfill_irq)
		else $error("padfill interrupt while disabled");

	AST_EOP_ON: assert property (@(posedge ref_clk) disable iff (srst)
		(tx_padfill_done && tx_cfg.end_padfill_irq_enable) |=> end_padfill_irq ##1 events_ff[hcc_pkg::EV_PADFILL])
		else $error("padfill interrupt missing");

	AST_ERR_INC: assert property (@(posedge ref_clk) disable iff (srst)
		err_inc_irq |-> $past(err_count_inc && ss7_rx && rx_cfg.err_inc_irq_enable))
		else $error("error increment interrupt without cause");

	AST_ERR_DEC: assert property (@(posedge ref_clk) disable iff (srst)
		(err_count_dec && ss7_rx && rx_cfg.err_dec_irq_enable) |=> err_dec_irq)
		else $error("error decrement interrupt missing");

	AST_DUP: assert property (@(posedge ref_clk) disable iff (srst)
		(rx_duplicate && !ss7_rx) |=> !dup_irq)
		else $error("duplicate interrupt outside ss7");

	AST_FCS: assert property (@(posedge ref_clk) disable iff (srst)
		rx_setup.store_fcs |-> !rx_setup.send_fcs)
		else $error("fcs both stored and sent");

	AST_INV: assert property (@(posedge ref_clk) disable iff (srst)
		!tx_cfg.data_complement |=> !tx_setup.data_complement)
		else $error("inversion reported while clear");

	AST_SIZE: assert property (@(posedge ref_clk) disable iff (srst)
		1'b1 |=> tx_setup.fifo_words == 7'($past(tx_cfg.fifo_length_code)) * 7'h02 + 7'h02)
		else $error("fifo size decode wrong");

	AST_ERR_INC_ON: assert property (@(posedge ref_clk) disable iff (srst)
		(err_count_inc && ss7_rx && rx_cfg.err_inc_irq_enable) |=> err_inc_irq)
		else $error("error increment interrupt missing");

	AST_ERR_DEC_CAUSE: assert property (@(posedge ref_clk) disable iff (srst)
		err_dec_irq |-> $past(err_count_dec && ss7_rx && rx_cfg.err_dec_irq_enable))
		else $error("error decrement interrupt without cause");

	AST_DUP_ON: assert property (@(posedge ref_clk) disable iff (srst)
		(rx_duplicate && ss7_rx && rx_cfg.dup_irq_enable) |=> dup_irq)
		else $error("duplicate interrupt missing");

	AST_START: assert property (@(posedge ref_clk) disable iff (srst)
		1'b1 |=> rx_setup.fifo_start_index == $past(rx_cfg.fifo_start_index))
		else $error("fifo start index not passed on");

	AST_PROTO: assert property (@(posedge ref_clk) disable iff (srst)
		1'b1 |=> tx_setup.protocol == $past(tx_cfg.protocol))
		else $error("protocol select not passed on");

	AST_FCS_NORMAL: assert property (@(posedge ref_clk) disable iff (srst)
		(tx_cfg.protocol != hcc_pkg::PROTO_TRANSPARENT && !tx_cfg.fcs_pass_through)
		|=> (tx_setup.send_fcs && !tx_setup.store_fcs))
		else $error("normal fcs mode not decoded");

	AST_FCS_PASS: assert property (@(posedge ref_clk) disable iff (srst)
		rx_cfg.fcs_pass_through |=> (rx_setup.store_fcs && !rx_setup.send_fcs))
		else $error("fcs pass-through mode not decoded");

	AST_CFG_WRITE: assert property (@(posedge ref_clk) disable iff (srst)
		(wr_go && in_cfg && avs_byteenable == 4'hF)
		|=> cfg_mem[$past(cfg_idx)] == ($past(avs_writedata) & hcc_pkg::CFG_WMASK))
		else $error("configuration word not stored");

	AST_LEN_EVENT: assert property (@(posedge ref_clk) disable iff (srst)
		rx_length_error |=> events_ff[hcc_pkg::EV_LENGTH])
		else $error("length event not recorded");

endmodule : hcc_channel_config

// file: sim/hcc_host_model.sv
`timescale 1ns/10ps
module hcc_host_model
(
	input  wire logic                  ref_clk,
	input  wire logic                  avs_waitrequest,
	input  wire logic [31:0]           avs_readdata,
	output logic [hcc_pkg::ADDR_W-1:0] avs_address,
	output logic                       avs_read,
	output logic                       avs_write,
	output logic [3:0]                 avs_byteenable,
	output logic [31:0]                avs_writedata,
	output logic                       hung
);
	initial
	begin
		avs_address = 10'h000;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_byteenable = 4'h0;
		avs_writedata = 32'h0000_0000;
		hung = 1'b0;
	end

	// released address and write data lines are inverted so a stale value never looks valid
	task automatic xfer(input logic rnw, input logic [9:0] a, input logic [31:0] d, input logic [3:0] be,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_address <= a;
		avs_read <= rnw;
		avs_write <= !rnw;
		avs_byteenable <= be;
		avs_writedata <= d;
		// waitrequest and readdata are looked at on rising edges only
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 20);
		hung = hung | (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_address <= ~a;
		avs_writedata <= ~d;
	endtask : xfer
endmodule : hcc_host_model

// file: sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	logic                       ref_clk = 1'b0;
	logic                       srst = 1'b1;
	logic [hcc_pkg::ADDR_W-1:0] adr;
	logic                       rd_en;
	logic                       wr_en;
	logic [3:0]                 be;
	logic [31:0]                wd;
	logic [31:0]                rdat;
	logic                       wreq;
	logic [4:0]                 tc = 5'h03;
	logic [4:0]                 rc = 5'h05;
	hcc_pkg::hcc_chan_s         tset;
	hcc_pkg::hcc_chan_s         rset;
	logic [7:0]                 ev = 8'h00;
	logic [7:0]                 pv = 8'h00;
	logic [7:0]                 pad;
	logic [4:0]                 irqs;
	int                         err_total = 0;
	int                         n_compared = 0;
	logic [9:0]                 ra [5] = '{10'h000, 10'h0FC, 10'h100, 10'h104, 10'h108};
	logic [31:0]                rv [5] = '{32'h0, 32'h0, 32'h0000_3FFF, 32'h0000_3FFF, 32'h0};
	logic [31:0]                lw [4] = '{32'h0000_0400, 32'h0000_0800, 32'h0000_0000, 32'h0000_0C00};
	int                         lok [4] = '{2, 1, 4, 4};

	always #2.5 ref_clk = ~ref_clk;

	hcc_host_model hcc_host_model_i (.ref_clk(ref_clk), .avs_waitrequest(wreq), .avs_readdata(rdat),
		.avs_address(adr), .avs_read(rd_en), .avs_write(wr_en), .avs_byteenable(be), .avs_writedata(wd),
		.hung());

	hcc_channel_config hcc_channel_config_i (.ref_clk(ref_clk), .srst(srst), .avs_address(adr),
		.avs_read(rd_en), .avs_write(wr_en), .avs_byteenable(be), .avs_writedata(wd), .avs_readdata(rdat),
		.avs_waitrequest(wreq), .tx_chan(tc), .rx_chan(rc), .tx_setup(tset), .rx_setup(rset),
		.tx_pad_load(ev[7]), .tx_pad_value(pv), .tx_zero_insert(ev[6]), .pad_fill_count(pad),
		.tx_padfill_done(ev[5]), .end_padfill_irq(irqs[4]), .rx_byte_valid(ev[4]), .rx_msg_end(ev[3]),
		.rx_length_error(irqs[0]), .err_count_inc(ev[2]), .err_count_dec(ev[1]), .rx_duplicate(ev[0]),
		.err_inc_irq(irqs[3]), .err_dec_irq(irqs[2]), .dup_irq(irqs[1]));

	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			$display("Error at %0t: got %h expected %h", $time, g, e);
			err_total++;
		end
	endtask : chk

	task automatic acc(input logic rnw, input logic [9:0] a, input logic [31:0] d, input logic [3:0] m,
		output logic [31:0] q);
		hcc_host_model_i.xfer(rnw, a, d, m, q);
		if (hcc_host_model_i.hung)
		begin
			err_total++;
			end_sim();
		end
	endtask : acc

	task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] m = 4'hF);
		logic [31:0] q;
		acc(1'b0, a, d, m, q);
	endtask : wr

	task automatic rd(input logic [9:0] a, input logic [31:0] e);
		logic [31:0] q;
		acc(1'b1, a, 32'h0000_0000, 4'hF, q);
		chk(q, e);
	endtask : rd

	// one datapath pulse, then the registered answer one cycle on
	task automatic pl(input logic [7:0] v, input logic [4:0] e);
		@(posedge ref_clk);
		ev <= v;
		@(posedge ref_clk);
		ev <= 8'h00;
		@(negedge ref_clk);
		chk({27'h0, irqs}, {27'h0, e});
	endtask : pl

	task automatic setup_chk(input logic [18:0] et, input logic [18:0] er);
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		chk({13'h0, tset}, {13'h0, et});
		chk({13'h0, rset}, {13'h0, er});
	endtask : setup_chk

	initial
	begin
		repeat (10) @(posedge ref_clk);
		srst <= 1'b0;
		for (int i = 0; i < 5; i++)
			rd(ra[i], rv[i]);
		rd(10'h200, 32'h0000_0000);
		$display("reset values done");

		wr(10'h00C, 32'hFFFF_FFFF);
		wr(10'h08C, 32'h0000_1234);
		rd(10'h00C, 32'hBFBF_FFC0);
		rd(10'h08C, 32'h0000_1200);
		wr(10'h00C, 32'h0000_0000, 4'h2);
		rd(10'h00C, 32'hBFBF_00C0);
		$display("masks and lanes done");

		wr(10'h00C, 32'h2ABE_2000);
		wr(10'h094, 32'h0100_3200);
		setup_chk({6'h2A, 7'h7E, 1'b1, 1'b1, 1'b0, 3'h2}, {6'h01, 7'h02, 1'b0, 1'b0, 1'b1, 3'h3});
		@(posedge ref_clk);
		tc <= 5'h04;
		setup_chk({6'h00, 7'h02, 1'b0, 1'b0, 1'b0, 3'h0}, {6'h01, 7'h02, 1'b0, 1'b0, 1'b1, 3'h3});
		@(posedge ref_clk);
		tc <= 5'h03;
		$display("channel setup done");

		pv <= 8'h05;
		pl(8'h80, 5'h00);
		pl(8'h40, 5'h00);
		chk({24'h0, pad}, 32'h0000_0005);
		wr(10'h00C, 32'hAABE_2000);
		pl(8'h40, 5'h00);
		chk({24'h0, pad}, 32'h0000_0004);
		@(posedge ref_clk);
		pv <= 8'h00;
		pl(8'h80, 5'h00);
		pl(8'h40, 5'h00);
		chk({24'h0, pad}, 32'h0000_0000);
		$display("pad adjust done");

		pl(8'h20, 5'h00);
		rd(10'h108, 32'h0000_0000);
		wr(10'h00C, 32'hAABE_A000);
		pl(8'h20, 5'h10);
		rd(10'h108, 32'h0000_0001);
		wr(10'h108, 32'h0000_0001);
		rd(10'h108, 32'h0000_0000);
		$display("padfill interrupt done");

		wr(10'h094, 32'h0000_11C0);
		pl(8'h04, 5'h08);
		pl(8'h02, 5'h04);
		pl(8'h01, 5'h02);
		pl(8'h07, 5'h0E);
		rd(10'h108, 32'h0000_000E);
		wr(10'h108, 32'h0000_000E);
		wr(10'h094, 32'h0000_21C0);
		pl(8'h07, 5'h00);
		wr(10'h094, 32'h0000_1000);
		pl(8'h07, 5'h00);
		$display("error monitor done");

		wr(10'h100, 32'h0000_0002);
		wr(10'h104, 32'h0000_0001);
		for (int i = 0; i < 4; i++)
		begin
			wr(10'h094, lw[i]);
			repeat (lok[i]) pl(8'h10, 5'h00);
			if (i < 2)
				pl(8'h10, 5'h01);
			pl(8'h08, 5'h00);
		end
		rd(10'h108, 32'h0000_0010);
		$display("length check done");
		end_sim();
	end
endmodule : tb_top
